// ### src/sfp_core.v
// Serial flash front end: select framing, command capture, sector protection,
// OTP area, suspend control and hand-off of self-timed work to the array.
// Assumes sck, cs_n, si and wp_n are synchronous to clk_sys, that sck stays
// high and low at least four clk_sys periods each, and that the array answers
// arr_rd with arr_rdata on the next cycle and reports its work on arr_busy.
//
// Behaviour
// - Deselect gives ordinary standby, never deep power-down.
// - Serial output released while deselected.
// - Serial input ignored while deselected.
// - Only a falling select edge starts decoding.
// - A rising select edge ends and executes the transaction; OTP write bytes are stored as each one arrives.
// - Standby waits for a running program or erase.
// - Clock modes 0 and 3 both work.
// - Erase of 4KB, 32KB, 64KB blocks and the whole array.
// - Sixty-four 64KB sectors, each protectable alone.
// - Global protect and unprotect act on every sector.
// - Write-protect pin low freezes protected sectors.
// - Locked sectors refuse later program and erase.
// - A 128-byte one-time-programmable area apart from the array.
// - One program takes 1 to 256 data bytes.
// - Program or erase can be suspended and resumed.
// - Program and erase failures are reported in status.
// - Identification read returns maker and device identifiers.
// - Inputs taken on rising sck, outputs launched on falling sck.
`include "sfp_defs.vh"

module sfp_core #(
    parameter [7:0]  MFR_ID = 8'h5A,    // Arbitrary value.
    parameter [15:0] DEV_ID = 16'hA5C3  // Arbitrary value.
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire        sck,
    input  wire        cs_n,
    input  wire        si,
    input  wire        wp_n,
    output wire        so,
    output wire        so_oe,
    output wire        standby,
    output wire        arr_rd,
    output wire        arr_load,
    output wire        arr_go,
    output wire [2:0]  arr_op,
    output wire [21:0] arr_addr,
    output wire [7:0]  arr_wdata,
    output wire        arr_suspend,
    output wire        arr_resume,
    input  wire [7:0]  arr_rdata,
    input  wire        arr_busy,
    input  wire        arr_fail
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_CMD  = 3'h1;
    localparam [2:0] ST_ADDR = 3'h2;
    localparam [2:0] ST_DIN  = 3'h3;
    localparam [2:0] ST_DOUT = 3'h4;
    localparam [2:0] ST_IGN  = 3'h5;

    wire        sck_rise;
    wire        sck_fall;
    wire        cs_rise;
    wire        cs_fall;
    wire [7:0]  byte_in;
    wire        byte_done;
    wire [5:0]  sect;
    wire        blocked;
    wire [8:0]  pg_sum;
    wire [7:0]  otp_sum;
    reg  [7:0]  status_w;
    reg  [7:0]  out_byte;

    reg         sel_r;
    reg  [2:0]  state_r;
    reg  [2:0]  bit_cnt_r;
    reg  [7:0]  sh_in_r;
    reg  [7:0]  cmd_r;
    reg  [23:0] addr_r;
    reg  [1:0]  abyte_r;
    reg  [8:0]  nbytes_r;
    reg         cmd_ok_r;
    reg         fetch_r;
    reg         load_r;
    reg  [1:0]  id_idx_r;
    reg         arr_rd_r;
    reg         arr_load_r;
    reg  [21:0] arr_addr_r;
    reg  [7:0]  arr_wdata_r;
    reg         otp_we_r;
    reg  [6:0]  otp_idx_r;
    reg  [7:0]  otp_wd_r;
    reg  [127:0] otp_wr_r;
    reg  [7:0]  otp_mem [0:`SFP_OTP_BYTES-1];

    reg  [63:0] prot_r;
    reg  [63:0] lock_r;
    reg         fail_r;
    reg         perr_r;
    reg         susp_r;
    reg         busy_q_r;
    reg         standby_r;
    reg         arr_go_r;
    reg  [2:0]  arr_op_r;
    reg         arr_suspend_r;
    reg         arr_resume_r;

    // Sector number of a byte address.
    function [5:0] sect_of;
        input [23:0] a;
        begin
            sect_of = a[`SFP_SECT_HI:`SFP_SECT_LO];
        end
    endfunction

    // Opcodes that carry a three-byte address.
    function op_addr;
        input [7:0] op;
        begin
            case (op)
                `SFP_OP_READ, `SFP_OP_PROG, `SFP_OP_ER4K, `SFP_OP_ER32K,
                `SFP_OP_ER64K, `SFP_OP_PROT, `SFP_OP_UNPROT, `SFP_OP_LOCK,
                `SFP_OP_OTPW, `SFP_OP_OTPR:
                    op_addr = 1'b1;
                default:
                    op_addr = 1'b0;
            endcase
        end
    endfunction

    // Opcodes accepted in the present array state; unknown ones are ignored.
    function op_allowed;
        input [7:0] op;
        input       busy;
        input       susp;
        begin
            case (op)
                `SFP_OP_RDSR:
                    op_allowed = 1'b1;
                `SFP_OP_SUSP:
                    op_allowed = busy;
                `SFP_OP_RESUME:
                    op_allowed = susp & ~busy;
                `SFP_OP_READ, `SFP_OP_RDID, `SFP_OP_OTPR:
                    op_allowed = ~busy;
                `SFP_OP_PROG, `SFP_OP_ER4K, `SFP_OP_ER32K, `SFP_OP_ER64K,
                `SFP_OP_CHIP, `SFP_OP_PROT, `SFP_OP_UNPROT, `SFP_OP_GPROT,
                `SFP_OP_GUNPROT, `SFP_OP_LOCK, `SFP_OP_OTPW:
                    op_allowed = ~busy & ~susp;
                default:
                    op_allowed = 1'b0;
            endcase
        end
    endfunction

    // Array operation code for a program or erase opcode.
    function [2:0] aop_of;
        input [7:0] op;
        begin
            case (op)
                `SFP_OP_ER4K:  aop_of = `SFP_AOP_ER4K;
                `SFP_OP_ER32K: aop_of = `SFP_AOP_ER32K;
                `SFP_OP_ER64K: aop_of = `SFP_AOP_ER64K;
                `SFP_OP_CHIP:  aop_of = `SFP_AOP_CHIP;
                default:       aop_of = `SFP_AOP_PROG;
            endcase
        end
    endfunction

    sfp_pin_edge u_edge (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .sck      (sck),
        .cs_n     (cs_n),
        .sck_rise (sck_rise),
        .sck_fall (sck_fall),
        .cs_rise  (cs_rise),
        .cs_fall  (cs_fall)
    );

    // Only edges matter, so a clock idling low or high works alike.
    assign byte_in   = {sh_in_r[6:0], si};
    assign byte_done = sel_r & sck_rise & (bit_cnt_r == `SFP_BIT_LAST);
    assign sect      = sect_of(addr_r);
    assign blocked   = prot_r[sect] | lock_r[sect];
    assign pg_sum    = {1'b0, addr_r[7:0]} + {1'b0, nbytes_r[7:0]};
    assign otp_sum   = {1'b0, addr_r[`SFP_OTP_HI:0]} + 8'h01;

    // Status byte; the pin level is shown so software sees the hardware lock.
    always @*
    begin
        status_w = 8'h00;
        status_w[`SFP_ST_BUSY] = arr_busy;
        status_w[`SFP_ST_FAIL] = fail_r;
        status_w[`SFP_ST_SUSP] = susp_r;
        status_w[`SFP_ST_WPL]  = wp_n;
        status_w[`SFP_ST_PERR] = perr_r;
    end

    // Source of the next outgoing byte.
    always @*
    begin
        case (cmd_r)
            `SFP_OP_READ:
                out_byte = arr_rdata;
            `SFP_OP_OTPR:
                out_byte = otp_wr_r[addr_r[`SFP_OTP_HI:0]] ?
                           otp_mem[addr_r[`SFP_OTP_HI:0]] : `SFP_BYTE_ERASED;
            `SFP_OP_RDID:
                case (id_idx_r)
                    2'h0:    out_byte = MFR_ID;
                    2'h1:    out_byte = DEV_ID[15:8];
                    2'h2:    out_byte = DEV_ID[7:0];
                    default: out_byte = 8'h00;
                endcase
            default:
                out_byte = status_w;
        endcase
    end

    // Framing and capture. Select edges outrank clock edges, so a clock edge
    // that lands on the select edge is never taken as a data bit.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sel_r       <= 1'b0;
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 3'h0;
            sh_in_r     <= 8'h00;
            cmd_r       <= 8'h00;
            addr_r      <= 24'h000000;
            abyte_r     <= 2'h0;
            nbytes_r    <= 9'h000;
            cmd_ok_r    <= 1'b0;
            fetch_r     <= 1'b0;
            load_r      <= 1'b0;
            id_idx_r    <= 2'h0;
            arr_rd_r    <= 1'b0;
            arr_load_r  <= 1'b0;
            arr_addr_r  <= 22'h000000;
            arr_wdata_r <= 8'h00;
            otp_we_r    <= 1'b0;
            otp_idx_r   <= 7'h00;
            otp_wd_r    <= 8'h00;
        end
        else
        begin
            arr_rd_r   <= 1'b0;
            arr_load_r <= 1'b0;
            otp_we_r   <= 1'b0;
            fetch_r    <= 1'b0;
            load_r     <= fetch_r;
            if (load_r)
            begin
                // Advance the read pointer once the byte sits in the shifter.
                case (cmd_r)
                    `SFP_OP_READ: addr_r <= addr_r + 24'h000001;
                    `SFP_OP_OTPR: addr_r[`SFP_OTP_HI:0] <= otp_sum[`SFP_OTP_HI:0];
                    `SFP_OP_RDID:
                        if (id_idx_r != `SFP_ID_LAST)
                            id_idx_r <= id_idx_r + 2'h1;
                    default: ;
                endcase
            end
            if (cs_rise)
            begin
                sel_r      <= 1'b0;
                state_r    <= ST_IDLE;
                arr_addr_r <= addr_r[`SFP_SECT_HI:0];
            end
            else if (cs_fall)
            begin
                sel_r     <= 1'b1;
                state_r   <= ST_CMD;
                bit_cnt_r <= 3'h0;
                abyte_r   <= 2'h0;
                nbytes_r  <= 9'h000;
                cmd_ok_r  <= 1'b0;
                id_idx_r  <= 2'h0;
            end
            else if (sel_r && sck_rise)
            begin
                sh_in_r   <= byte_in;
                bit_cnt_r <= bit_cnt_r + 3'h1;
            end
            if (byte_done && !cs_rise && !cs_fall)
            begin
                case (state_r)
                    ST_CMD:
                    begin
                        cmd_r <= byte_in;
                        if (!op_allowed(byte_in, arr_busy, susp_r))
                            state_r <= ST_IGN;
                        else if (op_addr(byte_in))
                            state_r <= ST_ADDR;
                        else if (byte_in == `SFP_OP_RDSR || byte_in == `SFP_OP_RDID)
                        begin
                            state_r <= ST_DOUT;
                            fetch_r <= 1'b1;
                        end
                        else
                        begin
                            cmd_ok_r <= 1'b1;
                            state_r  <= ST_IGN;
                        end
                    end
                    ST_ADDR:
                    begin
                        addr_r  <= {addr_r[15:0], byte_in};
                        abyte_r <= abyte_r + 2'h1;
                        if (abyte_r == `SFP_ADDR_LASTB)
                        begin
                            case (cmd_r)
                                `SFP_OP_READ, `SFP_OP_OTPR:
                                begin
                                    state_r    <= ST_DOUT;
                                    fetch_r    <= 1'b1;
                                    arr_rd_r   <= (cmd_r == `SFP_OP_READ);
                                    arr_addr_r <= {addr_r[13:0], byte_in};
                                end
                                `SFP_OP_PROG, `SFP_OP_OTPW:
                                    state_r <= ST_DIN;
                                default:
                                begin
                                    cmd_ok_r <= 1'b1;
                                    state_r  <= ST_IGN;
                                end
                            endcase
                        end
                    end
                    ST_DIN:
                    begin
                        cmd_ok_r <= 1'b1;
                        if (cmd_r == `SFP_OP_PROG)
                        begin
                            // Bytes past a full page are dropped, not wrapped.
                            if (!blocked && nbytes_r != `SFP_PAGE_MAX)
                            begin
                                arr_load_r  <= 1'b1;
                                arr_wdata_r <= byte_in;
                                arr_addr_r  <= {addr_r[`SFP_SECT_HI:8], pg_sum[7:0]};
                                nbytes_r    <= nbytes_r + 9'h001;
                            end
                        end
                        else
                        begin
                            // Each OTP byte accepts one write until reset clears the written map.
                            otp_we_r  <= ~otp_wr_r[addr_r[`SFP_OTP_HI:0]];
                            otp_idx_r <= addr_r[`SFP_OTP_HI:0];
                            otp_wd_r  <= byte_in;
                            addr_r[`SFP_OTP_HI:0] <= otp_sum[`SFP_OTP_HI:0];
                        end
                    end
                    ST_DOUT:
                    begin
                        fetch_r    <= 1'b1;
                        arr_rd_r   <= (cmd_r == `SFP_OP_READ);
                        arr_addr_r <= addr_r[`SFP_SECT_HI:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    // OTP storage has no reset; the written map decides what reads return.
    always @(posedge clk_sys)
    begin
        if (otp_we_r)
            otp_mem[otp_idx_r] <= otp_wd_r;
    end

    // Written map of the OTP bytes.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            otp_wr_r <= 128'h0;
        else if (otp_we_r)
            otp_wr_r[otp_idx_r] <= 1'b1;
    end

    // Execution at the end of a frame, protection state and failure flags.
    // A refused action sets the protection error flag instead of acting.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prot_r        <= `SFP_PROT_ALL;
            lock_r        <= `SFP_PROT_NONE;
            fail_r        <= 1'b0;
            perr_r        <= 1'b0;
            susp_r        <= 1'b0;
            busy_q_r      <= 1'b0;
            standby_r     <= 1'b1;
            arr_go_r      <= 1'b0;
            arr_op_r      <= `SFP_AOP_PROG;
            arr_suspend_r <= 1'b0;
            arr_resume_r  <= 1'b0;
        end
        else
        begin
            arr_go_r      <= 1'b0;
            arr_suspend_r <= 1'b0;
            arr_resume_r  <= 1'b0;
            busy_q_r      <= arr_busy;
            standby_r     <= ~sel_r & ~arr_busy;
            if (cs_rise && sel_r && cmd_ok_r)
            begin
                case (cmd_r)
                    `SFP_OP_PROG, `SFP_OP_ER4K, `SFP_OP_ER32K, `SFP_OP_ER64K:
                        if (blocked)
                            perr_r <= 1'b1;
                        else if (cmd_r != `SFP_OP_PROG || nbytes_r != 9'h000)
                        begin
                            arr_go_r <= 1'b1;
                            arr_op_r <= aop_of(cmd_r);
                            fail_r   <= 1'b0;
                            perr_r   <= 1'b0;
                        end
                    `SFP_OP_CHIP:
                        if ((|prot_r) || (|lock_r))
                            perr_r <= 1'b1;
                        else
                        begin
                            arr_go_r <= 1'b1;
                            arr_op_r <= `SFP_AOP_CHIP;
                            fail_r   <= 1'b0;
                            perr_r   <= 1'b0;
                        end
                    `SFP_OP_PROT:
                        prot_r[sect] <= 1'b1;
                    `SFP_OP_UNPROT:
                        if (!wp_n && prot_r[sect])
                            perr_r <= 1'b1;
                        else
                            prot_r[sect] <= 1'b0;
                    `SFP_OP_GPROT:
                        prot_r <= `SFP_PROT_ALL;
                    `SFP_OP_GUNPROT:
                        if (!wp_n)
                            perr_r <= 1'b1;
                        else
                            prot_r <= `SFP_PROT_NONE;
                    `SFP_OP_LOCK:
                        lock_r[sect] <= 1'b1;
                    `SFP_OP_SUSP:
                        if (arr_busy)
                        begin
                            arr_suspend_r <= 1'b1;
                            susp_r        <= 1'b1;
                        end
                    `SFP_OP_RESUME:
                        if (susp_r)
                        begin
                            arr_resume_r <= 1'b1;
                            susp_r       <= 1'b0;
                        end
                    default: ;
                endcase
            end
            // Placed last so a failure landing with a new start is kept.
            if (busy_q_r && !arr_busy && !susp_r && arr_fail)
                fail_r <= 1'b1;
        end
    end

    // The output is driven only in an output phase of a selected frame.
    sfp_tx_shift u_tx (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .load      (load_r),
        .load_byte (out_byte),
        .shift     (sck_fall & sel_r),
        .drive     (sel_r & (state_r == ST_DOUT) & ~cs_rise),
        .so        (so),
        .so_oe     (so_oe)
    );

    assign standby     = standby_r;
    assign arr_rd      = arr_rd_r;
    assign arr_load    = arr_load_r;
    assign arr_go      = arr_go_r;
    assign arr_op      = arr_op_r;
    assign arr_addr    = arr_addr_r;
    assign arr_wdata   = arr_wdata_r;
    assign arr_suspend = arr_suspend_r;
    assign arr_resume  = arr_resume_r;
endmodule

// ### src/sfp_defs.vh
// Shared constants of the serial flash select framing and protection block.
// Included by bare name from every design file of the block; definitions only.
`ifndef SFP_DEFS_VH
`define SFP_DEFS_VH

// Opcodes received on the serial input.
`define SFP_OP_READ     8'h03
`define SFP_OP_PROG     8'h02
`define SFP_OP_ER4K     8'h20
`define SFP_OP_ER32K    8'h52
`define SFP_OP_ER64K    8'hD8
`define SFP_OP_CHIP     8'hC7
`define SFP_OP_PROT     8'h36
`define SFP_OP_UNPROT   8'h39
`define SFP_OP_GPROT    8'h7E
`define SFP_OP_GUNPROT  8'h98
`define SFP_OP_LOCK     8'h33
`define SFP_OP_OTPW     8'h9B
`define SFP_OP_OTPR     8'h77
`define SFP_OP_SUSP     8'hB0
`define SFP_OP_RESUME   8'hD0
`define SFP_OP_RDSR     8'h05
`define SFP_OP_RDID     8'h9F

// Self-timed array operation codes on arr_op.
`define SFP_AOP_PROG    3'h0
`define SFP_AOP_ER4K    3'h1
`define SFP_AOP_ER32K   3'h2
`define SFP_AOP_ER64K   3'h3
`define SFP_AOP_CHIP    3'h4

// Status byte bit positions.
`define SFP_ST_BUSY     0
`define SFP_ST_FAIL     1
`define SFP_ST_SUSP     2
`define SFP_ST_WPL      3
`define SFP_ST_PERR     4

// Geometry and counts.
`define SFP_SECT_HI     21
`define SFP_SECT_LO     16
`define SFP_BIT_LAST    3'h7
`define SFP_ADDR_LASTB  2'h2
`define SFP_PAGE_MAX    9'h100
`define SFP_OTP_HI      6
`define SFP_OTP_BYTES   128
`define SFP_ID_LAST     2'h3

// Reset and fixed values.
`define SFP_PROT_ALL    64'hFFFF_FFFF_FFFF_FFFF
`define SFP_PROT_NONE   64'h0000_0000_0000_0000
`define SFP_BYTE_ERASED 8'hFF
`define SFP_PIN_IDLE    2'h2

`endif

// ### src/sfp_pin_edge.v
// Edge detector for the serial clock and chip select pins.
// Assumes both pins are already synchronous to clk_sys.
`include "sfp_defs.vh"

module sfp_pin_edge (
    input  wire clk_sys,
    input  wire rst_n,
    input  wire sck,
    input  wire cs_n,
    output wire sck_rise,
    output wire sck_fall,
    output wire cs_rise,
    output wire cs_fall
);
    wire [1:0] pin_now;
    wire [1:0] rise;
    wire [1:0] fall;
    reg  [1:0] pin_q_r;

    assign pin_now = {cs_n, sck};

    // Previous levels; reset shows select idle, so a select held low at release starts a frame.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            pin_q_r <= `SFP_PIN_IDLE;
        else
            pin_q_r <= pin_now;
    end

    // One edge pair per pin.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1)
        begin : g_edge
            assign rise[i] = pin_now[i] & ~pin_q_r[i];
            assign fall[i] = ~pin_now[i] & pin_q_r[i];
        end
    endgenerate

    assign sck_rise = rise[0];
    assign sck_fall = fall[0];
    assign cs_rise  = rise[1];
    assign cs_fall  = fall[1];
endmodule

// ### src/sfp_tx_shift.v
// Output shifter for the serial output pin and its enable.
// Assumes a load never coincides with a shift edge (sck slow versus clk_sys).
`include "sfp_defs.vh"

module sfp_tx_shift (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       load,
    input  wire [7:0] load_byte,
    input  wire       shift,
    input  wire       drive,
    output wire       so,
    output wire       so_oe
);
    reg [7:0] sh_r;
    reg       so_r;
    reg       oe_r;

    // Each falling sck edge launches the next bit, most significant first.
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sh_r <= 8'h00;
            so_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else
        begin
            oe_r <= drive;
            if (load)
                sh_r <= load_byte;
            else if (shift)
            begin
                so_r <= sh_r[7];
                sh_r <= {sh_r[6:0], 1'b0};
            end
            if (!drive)
                so_r <= 1'b0;  // Quiet level while released.
        end
    end

    assign so    = so_r;
    assign so_oe = oe_r;
endmodule

// ### tb/sfp_host_model.sv
// Host model for the flash link: mode 0 or 3 frames, samples the output pin.
// Assumes clk_sys is the bench clock; scenarios call frame() hierarchically.
module sfp_host_model (
    input  wire logic clk_sys,
    input  wire logic so,
    output logic      sck,
    output logic      cs_n,
    output logic      si
);
    timeunit 1ns;
    timeprecision 1ps;

    logic cpol = 1'h0; // Idle clock level: 0 for mode 0, 1 for mode 3.

    initial {sck, cs_n, si} = 3'h2;

    // One frame of n bytes, MSB first; si inverted after release.
    task automatic frame(input int n, input logic [47:0] tx, output logic [47:0] rx);
        rx = '0;
        @(negedge clk_sys) sck = cpol;
        @(negedge clk_sys) cs_n = 1'h0;
        for (int i = 0; i < 8 * n; i++)
        begin
            sck = 1'h0;
            si = tx[47 - i];
            repeat (4) @(negedge clk_sys);
            sck = 1'h1;
            rx[47 - i] = so;
            repeat (4) @(negedge clk_sys);
        end
        sck = cpol;
        repeat (2) @(negedge clk_sys);
        cs_n = 1'h1;
        si = ~si;
        repeat (5) @(negedge clk_sys);
    endtask
endmodule

// ### tb/sfp_core_sva.sv
// Checker on the front end ports: framing, output release, standby.
// Bound by the bench; one clock, async active-low reset.
module sfp_core_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic so,
    input wire logic so_oe,
    input wire logic standby,
    input wire logic arr_rd,
    input wire logic arr_load,
    input wire logic arr_go,
    input wire logic arr_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_OE_DESEL: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> !so_oe)
        else $error("output enabled while deselected");
    AST_SO_LOW: assert property (!so_oe |-> !so)
        else $error("output not low while released");
    AST_STBY_BUSY: assert property (arr_busy |=> !standby)
        else $error("standby while array busy");
    AST_STBY_SEL: assert property ($fell(cs_n) |-> ##4 !standby)
        else $error("still in standby after select");
    AST_STBY_IDLE: assert property ((cs_n && !arr_busy)[*5] |=> standby)
        else $error("no standby when idle");
    AST_GO_END: assert property (arr_go |-> $past(cs_n) && !$past(cs_n, 2))
        else $error("start without frame end");
    AST_LOAD_IN: assert property (arr_load |-> !$past(cs_n))
        else $error("load while deselected");
    AST_RD_IN: assert property (arr_rd |-> !$past(cs_n))
        else $error("read while deselected");
    AST_SO_FALL: assert property (so_oe && $past(so_oe) && $changed(so) |->
        $past(sck, 4) && !$past(sck)) else $error("output moved off falling clock");
endmodule

// ### tb/spi_flash_select_framing_protect_test.sv
// Bench: host model on the link, array stand-in below.
// One 40 MHz clock; scenarios run in order from one reset.
module spi_flash_select_framing_protect_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0]  MFR = 8'h6B;    // Arbitrary value.
    localparam logic [15:0] DEV = 16'h1E47; // Arbitrary value.
    logic        clk_sys;
    logic        rst_n;
    logic        wp_n;
    logic        arr_fail;
    logic        susp_r;
    logic [7:0]  arr_rdata;
    logic [7:0]  busy_r;
    logic [47:0] rx;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          go_n = 0;
    int          ld_n = 0;
    wire         arr_busy = busy_r != 8'h00 && !susp_r;
    wire         sck, cs_n, si, so, so_oe, standby, arr_load, arr_go, arr_suspend, arr_resume;
    wire [2:0]   arr_op;
    wire [21:0]  arr_addr;

    sfp_core #(.MFR_ID(MFR), .DEV_ID(DEV)) DUT (.*, .arr_rd(), .arr_wdata());
    sfp_host_model host (.*);

    // Array stand-in: data a cycle after the address, a 200-cycle job per start.
    always @(negedge clk_sys)
    begin
        arr_rdata <= arr_addr[7:0] ^ 8'h3C;
        busy_r <= arr_go ? 8'hC8 : busy_r - {7'h00, arr_busy};
        susp_r <= (susp_r | arr_suspend) & ~arr_resume;
        go_n <= go_n + int'(arr_go);
        ld_n <= ld_n + int'(arr_load);
    end

    // Clock generator.
    initial
    begin
        clk_sys = 1'h0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Reads the status byte and compares one bit of it.
    task automatic stat(input int b, input logic e);
        host.frame(2, {8'h05, 40'h0}, rx);
        check({7'h00, rx[32 + b]}, {7'h00, e});
    endtask

    // Bounded wait for the array job to end.
    task automatic idle();
        for (int i = 0; i < 400 && !standby; i++) @(negedge clk_sys);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ID read, then a mode 3 sequential read.
    task automatic t_read();
        host.frame(4, {8'h9F, 40'h0}, rx);
        check(rx[39:32], MFR);
        check(rx[23:16], DEV[7:0]);
        check({7'h00, so_oe}, 8'h00);
        check({7'h00, standby}, 8'h01);
        host.cpol = 1'h1;
        host.frame(6, {8'h03, 24'h1234FE, 16'h0}, rx);
        host.cpol = 1'h0;
        check(rx[15:8], 8'hC2);
        check(rx[7:0], 8'hC3);
    endtask

    // Refused program, unprotect, two-byte program; standby waits.
    task automatic t_prog();
        host.frame(5, {8'h02, 24'h050010, 16'hA500}, rx);
        stat(4, 1'h1);
        host.frame(4, {8'h39, 24'h050000, 16'h0}, rx);
        host.frame(6, {8'h02, 24'h050010, 16'hA55A}, rx);
        check(8'(go_n * 16 + ld_n), 8'h12);
        check({7'h00, standby}, 8'h00);
        idle();
        check({7'h00, standby}, 8'h01);
    endtask

    // One job code per block size; the last job fails.
    task automatic t_erase();
        logic [7:0] ops [3] = '{8'h20, 8'h52, 8'hD8};
        for (int k = 1; k < 4; k++)
        begin
            arr_fail = (k == 3);
            host.frame(4, {ops[k - 1], 24'h050000, 16'h0}, rx);
            check({5'h00, arr_op}, 8'(k));
            idle();
        end
        arr_fail = 1'h0;
        stat(1, 1'h1);
    endtask

    // Write protect, chip erase with suspend and resume, lock.
    task automatic t_global();
        wp_n = 1'h0;
        host.frame(1, {8'h98, 40'h0}, rx);
        stat(4, 1'h1);
        wp_n = 1'h1;
        host.frame(1, {8'h98, 40'h0}, rx);
        host.frame(1, {8'hC7, 40'h0}, rx);
        check({5'h00, arr_op}, 8'h04);
        host.frame(1, {8'hB0, 40'h0}, rx);
        stat(2, 1'h1);
        host.frame(1, {8'hD0, 40'h0}, rx);
        stat(2, 1'h0);
        idle();
        host.frame(4, {8'h33, 24'h050000, 16'h0}, rx);
        host.frame(4, {8'h39, 24'h050000, 16'h0}, rx);
        host.frame(4, {8'h20, 24'h050000, 16'h0}, rx);
        check(8'(go_n), 8'h05);
    endtask

    // Main sequence and watchdog.
    initial
    begin
        {rst_n, wp_n, arr_fail, susp_r, busy_r} = 12'h400;
        repeat (5) @(negedge clk_sys);
        rst_n = 1'h1;
        t_read();
        t_prog();
        t_erase();
        t_global();
        summarize();
    end

    initial
    begin
        #2ms;
        fail_count++;
        summarize();
    end
endmodule

bind sfp_core sfp_core_sva CHK (.*);
